/* dccu_pkg.sv */
package dccu_pkg;

    // Register byte addresses on the AXI4-Lite bus.
    localparam logic [7:0] OFF_U1_CTRL = 8'h00;
    localparam logic [7:0] OFF_U1_LOW = 8'h04;
    localparam logic [7:0] OFF_U1_HIGH = 8'h08;
    localparam logic [7:0] OFF_U2_CTRL = 8'h0c;
    localparam logic [7:0] OFF_U2_LOW = 8'h10;
    localparam logic [7:0] OFF_U2_HIGH = 8'h14;
    localparam logic [7:0] OFF_FLAGS = 8'h18;

    // Control register layout and reset.
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] CTRL_IMPL_MASK = 8'h3f;
    localparam int CTRL_MODE_LSB = 0;

    // Event flag positions inside the flag register.
    localparam int FLAG_U1_BIT = 2;
    localparam int FLAG_U2_BIT = 0;
    localparam logic [7:0] FLAGS_RESET = 8'h00;

    // Mode select codes.
    localparam logic [3:0] MODE_OFF = 4'h0;
    localparam logic [3:0] MODE_TOGGLE = 4'h2;
    localparam logic [3:0] MODE_CAP_FALL = 4'h4;
    localparam logic [3:0] MODE_CAP_RISE = 4'h5;
    localparam logic [3:0] MODE_CAP_4TH = 4'h6;
    localparam logic [3:0] MODE_CAP_16TH = 4'h7;
    localparam logic [3:0] MODE_SET_HIGH = 4'h8;
    localparam logic [3:0] MODE_SET_LOW = 4'h9;
    localparam logic [3:0] MODE_FLAG_ONLY = 4'ha;
    localparam logic [3:0] MODE_TRIGGER = 4'hb;

    // Prescaler terminal counts.
    localparam logic [1:0] PRESC_LAST_OF_4 = 2'h3;
    localparam logic [3:0] PRESC_LAST_OF_16 = 4'hf;

    // AXI responses.
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        RD_IDLE = 2'b01,
        RD_RESP = 2'b10
    } dccu_rd_e;

endpackage

/* dccu_unit_if.sv */
`timescale 1ns/100ps
`default_nettype none

interface dccu_unit_if;
    logic wr_ctrl;
    logic wr_low;
    logic wr_high;
    logic [7:0] wr_byte;
    logic [15:0] timer;
    logic pin_in;
    logic [7:0] control;
    logic [15:0] value;
    logic event_hit;
    logic trigger;
    logic pin_out;

    modport unit (
        input wr_ctrl, wr_low, wr_high, wr_byte, timer, pin_in,
        output control, value, event_hit, trigger, pin_out
    );
    modport host (
        output wr_ctrl, wr_low, wr_high, wr_byte, timer, pin_in,
        input control, value, event_hit, trigger, pin_out
    );
endinterface

`default_nettype wire

/* dccu_unit.sv */
`timescale 1ns/100ps
`default_nettype none

module dccu_unit import dccu_pkg::*; (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Register block side
    dccu_unit_if.unit port_if
);

    typedef struct packed {
        logic [7:0] control;
        logic [15:0] value;
        logic [3:0] presc;
        logic sync1;
        logic sync2;
        logic pin_prev;
        logic pin_out;
        logic event_hit;
        logic trigger;
    } dccu_unit_s;

    dccu_unit_s st;
    dccu_unit_s next_st;
    logic [3:0] mode;
    logic rise;
    logic fall;
    logic cap_hit;
    logic match;

    function automatic logic is_capture(input logic [3:0] m);
        return m[3:2] == 2'b01;
    endfunction

    function automatic logic is_compare(input logic [3:0] m);
        return (m == MODE_TOGGLE) || (m[3:2] == 2'b10);
    endfunction

    //////////////////////////////////////////////////////////////////////
    always_comb begin
        mode = st.control[CTRL_MODE_LSB +: 4];
        rise = st.sync2 & ~st.pin_prev;
        fall = ~st.sync2 & st.pin_prev;
        match = is_compare(mode) && (st.value == port_if.timer);
        cap_hit = 1'b0;
        next_st = st;
        next_st.sync1 = port_if.pin_in;
        next_st.sync2 = st.sync1;
        next_st.pin_prev = st.sync2;
        next_st.event_hit = 1'b0;
        next_st.trigger = 1'b0;
        // Mod 16 count of rising edges serves both prescalers; a prescale change keeps it.
        if (!is_capture(mode)) begin
            next_st.presc = 4'h0;
        end else if (rise) begin
            next_st.presc = st.presc + 4'h1;
        end
        case (mode)
            MODE_CAP_FALL: cap_hit = fall;
            MODE_CAP_RISE: cap_hit = rise;
            MODE_CAP_4TH: cap_hit = rise && (st.presc[1:0] == PRESC_LAST_OF_4);
            MODE_CAP_16TH: cap_hit = rise && (st.presc == PRESC_LAST_OF_16);
            default: cap_hit = 1'b0;
        endcase
        if (port_if.wr_low) begin
            next_st.value[7:0] = port_if.wr_byte;
        end
        if (port_if.wr_high) begin
            next_st.value[15:8] = port_if.wr_byte;
        end
        // A capture in the same cycle as a software write wins; no overrun is kept.
        if (cap_hit) begin
            next_st.value = port_if.timer;
            next_st.event_hit = 1'b1;
        end
        if (match) begin
            next_st.event_hit = 1'b1;
            case (mode)
                MODE_TOGGLE: next_st.pin_out = ~st.pin_out;
                MODE_SET_HIGH: next_st.pin_out = 1'b1;
                MODE_SET_LOW: next_st.pin_out = 1'b0;
                MODE_TRIGGER: next_st.trigger = 1'b1;
                default: next_st.pin_out = st.pin_out;
            endcase
        end
        if (port_if.wr_ctrl) begin
            next_st.control = port_if.wr_byte & CTRL_IMPL_MASK;
            case (port_if.wr_byte[3:0])
                MODE_OFF: begin
                    next_st.pin_out = 1'b0;
                    next_st.presc = 4'h0;
                    next_st.event_hit = 1'b0;
                    next_st.trigger = 1'b0;
                end
                MODE_SET_HIGH: next_st.pin_out = 1'b0;
                MODE_SET_LOW: next_st.pin_out = 1'b1;
                default: next_st.pin_out = next_st.pin_out;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign port_if.control = st.control;
    assign port_if.value = st.value;
    assign port_if.event_hit = st.event_hit;
    assign port_if.trigger = st.trigger;
    assign port_if.pin_out = st.pin_out;

    //////////////////////////////////////////////////////////////////////
    property p_capture_copy;
        @(posedge sys_clk) disable iff (!reset_n)
        (cap_hit && !port_if.wr_ctrl) |=> (st.value == $past(port_if.timer)) && st.event_hit;
    endproperty
    a_capture_copy: assert property (p_capture_copy)
        else $error("capture lost timer value");

    property p_presc_clear;
        @(posedge sys_clk) disable iff (!reset_n)
        !is_capture(mode) |=> (st.presc == 4'h0) || is_capture(mode);
    endproperty
    a_presc_clear: assert property (p_presc_clear)
        else $error("prescaler not cleared");

    property p_toggle;
        @(posedge sys_clk) disable iff (!reset_n)
        (match && mode == MODE_TOGGLE && !port_if.wr_ctrl) |=> st.pin_out != $past(st.pin_out);
    endproperty
    a_toggle: assert property (p_toggle)
        else $error("toggle on match missing");

    property p_trigger;
        @(posedge sys_clk) disable iff (!reset_n)
        st.trigger |-> $past(mode) == MODE_TRIGGER && st.event_hit;
    endproperty
    a_trigger: assert property (p_trigger)
        else $error("trigger without match in trigger mode");

    property p_ctrl_zero_top;
        @(posedge sys_clk) disable iff (!reset_n)
        port_if.wr_ctrl |=> st.control[7:6] == 2'b00;
    endproperty
    a_ctrl_zero_top: assert property (p_ctrl_zero_top)
        else $error("control top bits set");

endmodule // dccu_unit

`default_nettype wire

/* dccu_top.sv */
// Functional notes
// - Value is two byte registers, both read/write.
// - Mode 0000 disables the unit, resets state.
// - Capture codes select edge and prescale.
// - 1000/1001 initialise pin, force on match.
// - 0010 toggles pin; 11xx does nothing.
// - 1010 flag only; 1011 flag plus trigger.
// - Bits 5-4 are stored but have no function.
// - Control bits 7-6 read zero; rest reset.
// - Capture copies full timer into value.
// - Capture sets sticky flag, software clears.
// - New capture overwrites unread value silently.
// - Prescaler clears outside capture modes.
// - Prescale code change keeps the counter.
// - Compare every cycle; act and flag on equality.
// - Control written zero forces output latch low.
// - Unit 1 trigger resets the shared timer.
// - Unit 2 trigger resets timer, starts conversion.
// - Unit 2 trigger raises no overflow flag.
`timescale 1ns/100ps
`default_nettype none

module dccu_top import dccu_pkg::*; #(
    parameter int ADDR_W = 8
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // AXI4-Lite write address
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Unit pins
    input wire logic unit1_pin_in,
    input wire logic unit2_pin_in,
    output logic unit1_pin_out,
    output logic unit2_pin_out,
    // Shared timer and converter
    input wire logic [15:0] shared_timer_count,
    input wire logic adc_enabled,
    output logic timer_reset,
    output logic adc_start
);

    typedef struct packed {
        logic aw_got;
        logic w_got;
        logic [ADDR_W-1:0] awaddr;
        logic [7:0] wbyte;
        logic wlane0;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        dccu_rd_e rd_state;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [7:0] flags;
        logic [1:0] wr_ctrl;
        logic [1:0] wr_low;
        logic [1:0] wr_high;
        logic [7:0] wr_byte;
        logic timer_reset;
        logic adc_start;
    } dccu_top_s;

    dccu_top_s st;
    dccu_top_s next_st;
    logic [7:0] flag_set;
    logic [7:0] flag_clr;
    logic commit;

    dccu_unit_if u1_if();
    dccu_unit_if u2_if();

    //////////////////////////////////////////////////////////////////////
    // Register decode, shared by the read and write paths.

    function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
        case (8'(a))
            OFF_U1_CTRL, OFF_U1_LOW, OFF_U1_HIGH: return 1'b1;
            OFF_U2_CTRL, OFF_U2_LOW, OFF_U2_HIGH: return 1'b1;
            OFF_FLAGS: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction

    function automatic logic [31:0] read_word(input logic [ADDR_W-1:0] a,
                                              input logic [7:0] flags);
        logic [7:0] b;
        b = 8'h00;
        case (8'(a))
            OFF_U1_CTRL: b = u1_if.control;
            OFF_U1_LOW: b = u1_if.value[7:0];
            OFF_U1_HIGH: b = u1_if.value[15:8];
            OFF_U2_CTRL: b = u2_if.control;
            OFF_U2_LOW: b = u2_if.value[7:0];
            OFF_U2_HIGH: b = u2_if.value[15:8];
            OFF_FLAGS: b = flags;
            default: b = 8'h00;
        endcase
        return {24'h000000, b};
    endfunction

    //////////////////////////////////////////////////////////////////////
    always_comb begin
        flag_set = 8'h00;
        flag_set[FLAG_U1_BIT] = u1_if.event_hit;
        flag_set[FLAG_U2_BIT] = u2_if.event_hit;
        flag_clr = 8'h00;
        commit = st.aw_got && st.w_got && !st.bvalid;
        next_st = st;
        next_st.wr_ctrl = 2'b00;
        next_st.wr_low = 2'b00;
        next_st.wr_high = 2'b00;

        // Write address and data are taken in either order.
        if (s_axi_awvalid && st.awready) begin
            next_st.aw_got = 1'b1;
            next_st.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && st.wready) begin
            next_st.w_got = 1'b1;
            next_st.wbyte = s_axi_wdata[7:0];
            next_st.wlane0 = s_axi_wstrb[0];
        end
        if (commit) begin
            next_st.aw_got = 1'b0;
            next_st.w_got = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp = is_mapped(st.awaddr) ? RESP_OKAY : RESP_SLVERR;
            next_st.wr_byte = st.wbyte;
            // Registers are one byte wide, so only lane 0 carries a write.
            if (st.wlane0) begin
                case (8'(st.awaddr))
                    OFF_U1_CTRL: next_st.wr_ctrl[0] = 1'b1;
                    OFF_U1_LOW: next_st.wr_low[0] = 1'b1;
                    OFF_U1_HIGH: next_st.wr_high[0] = 1'b1;
                    OFF_U2_CTRL: next_st.wr_ctrl[1] = 1'b1;
                    OFF_U2_LOW: next_st.wr_low[1] = 1'b1;
                    OFF_U2_HIGH: next_st.wr_high[1] = 1'b1;
                    OFF_FLAGS: flag_clr = st.wbyte;
                    default: flag_clr = 8'h00;
                endcase
            end
        end else if (st.bvalid && s_axi_bready) begin
            next_st.bvalid = 1'b0;
        end
        next_st.awready = !next_st.aw_got && !next_st.bvalid;
        next_st.wready = !next_st.w_got && !next_st.bvalid;

        // Hardware set wins over a software clear in the same cycle.
        next_st.flags = (st.flags & ~flag_clr) | flag_set;

        case (st.rd_state)
            RD_IDLE: begin
                if (s_axi_arvalid && st.arready) begin
                    next_st.rd_state = RD_RESP;
                    next_st.arready = 1'b0;
                    next_st.rvalid = 1'b1;
                    next_st.rdata = read_word(s_axi_araddr, st.flags);
                    next_st.rresp = is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
                end
            end
            RD_RESP: begin
                if (s_axi_rready) begin
                    next_st.rd_state = RD_IDLE;
                    next_st.arready = 1'b1;
                    next_st.rvalid = 1'b0;
                end
            end
            default: begin
                next_st.rd_state = RD_IDLE;
                next_st.arready = 1'b1;
                next_st.rvalid = 1'b0;
            end
        endcase

        // Either trigger clears the timer through its reset input only,
        // so the timer's own overflow flag never sees it.
        next_st.timer_reset = u1_if.trigger | u2_if.trigger;
        next_st.adc_start = u2_if.trigger & adc_enabled;
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            st <= '0;
            st.awready <= 1'b1;
            st.wready <= 1'b1;
            st.arready <= 1'b1;
            st.rd_state <= RD_IDLE;
            st.flags <= FLAGS_RESET;
        end else begin
            st <= next_st;
        end
    end

    //////////////////////////////////////////////////////////////////////
    // Unit links.

    assign u1_if.wr_ctrl = st.wr_ctrl[0];
    assign u1_if.wr_low = st.wr_low[0];
    assign u1_if.wr_high = st.wr_high[0];
    assign u1_if.wr_byte = st.wr_byte;
    assign u1_if.timer = shared_timer_count;
    assign u1_if.pin_in = unit1_pin_in;
    assign u2_if.wr_ctrl = st.wr_ctrl[1];
    assign u2_if.wr_low = st.wr_low[1];
    assign u2_if.wr_high = st.wr_high[1];
    assign u2_if.wr_byte = st.wr_byte;
    assign u2_if.timer = shared_timer_count;
    assign u2_if.pin_in = unit2_pin_in;

    dccu_unit u_unit1 (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .port_if(u1_if.unit)
    );

    dccu_unit u_unit2 (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .port_if(u2_if.unit)
    );

    //////////////////////////////////////////////////////////////////////
    // Outputs, all straight from flops.

    assign s_axi_awready = st.awready;
    assign s_axi_wready = st.wready;
    assign s_axi_bvalid = st.bvalid;
    assign s_axi_bresp = st.bresp;
    assign s_axi_arready = st.arready;
    assign s_axi_rvalid = st.rvalid;
    assign s_axi_rdata = st.rdata;
    assign s_axi_rresp = st.rresp;
    assign unit1_pin_out = u1_if.pin_out;
    assign unit2_pin_out = u2_if.pin_out;
    assign timer_reset = st.timer_reset;
    assign adc_start = st.adc_start;

    //////////////////////////////////////////////////////////////////////
    property p_flag_set_wins;
        @(posedge sys_clk) disable iff (!reset_n)
        u1_if.event_hit |=> st.flags[FLAG_U1_BIT];
    endproperty
    a_flag_set_wins: assert property (p_flag_set_wins)
        else $error("unit 1 flag not set");

    property p_flag_sticky;
        @(posedge sys_clk) disable iff (!reset_n)
        (st.flags[FLAG_U1_BIT] && !(commit && st.wlane0 && 8'(st.awaddr) == OFF_FLAGS))
            |=> st.flags[FLAG_U1_BIT];
    endproperty
    a_flag_sticky: assert property (p_flag_sticky)
        else $error("unit 1 flag cleared by hardware");

    property p_timer_reset;
        @(posedge sys_clk) disable iff (!reset_n)
        u1_if.trigger |=> timer_reset;
    endproperty
    a_timer_reset: assert property (p_timer_reset)
        else $error("unit 1 trigger did not reset timer");

    property p_adc_start;
        @(posedge sys_clk) disable iff (!reset_n)
        adc_start |-> $past(u2_if.trigger) && $past(adc_enabled) && timer_reset;
    endproperty
    a_adc_start: assert property (p_adc_start)
        else $error("conversion start without unit 2 trigger");

    property p_zero_ctrl_low;
        @(posedge sys_clk) disable iff (!reset_n)
        (u1_if.wr_ctrl && u1_if.wr_byte == 8'h00) |=> !unit1_pin_out && u1_if.control == 8'h00;
    endproperty
    a_zero_ctrl_low: assert property (p_zero_ctrl_low)
        else $error("output latch not forced low");

    property p_bvalid_hold;
        @(posedge sys_clk) disable iff (!reset_n)
        (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_bvalid_hold: assert property (p_bvalid_hold) else $error("write response dropped early");

    property p_rvalid_hold;
        @(posedge sys_clk) disable iff (!reset_n)
        (s_axi_rvalid && !s_axi_rready) |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_rvalid_hold: assert property (p_rvalid_hold)
        else $error("read data dropped early");

    property p_u2_flag_set;
        @(posedge sys_clk) disable iff (!reset_n)
        u2_if.event_hit |=> st.flags[FLAG_U2_BIT];
    endproperty
    a_u2_flag_set: assert property (p_u2_flag_set)
        else $error("unit 2 flag not set");

    property p_u2_timer_reset;
        @(posedge sys_clk) disable iff (!reset_n)
        u2_if.trigger |=> timer_reset;
    endproperty
    a_u2_timer_reset: assert property (p_u2_timer_reset)
        else $error("unit 2 trigger did not reset timer");

    property p_adc_blocked;
        @(posedge sys_clk) disable iff (!reset_n)
        (u2_if.trigger && !adc_enabled) |=> !adc_start;
    endproperty
    a_adc_blocked: assert property (p_adc_blocked)
        else $error("conversion start while converter off");

    property p_timer_reset_cause;
        @(posedge sys_clk) disable iff (!reset_n)
        timer_reset |-> $past(u1_if.trigger) || $past(u2_if.trigger);
    endproperty
    a_timer_reset_cause: assert property (p_timer_reset_cause)
        else $error("timer reset without a trigger");

endmodule // dccu_top

`default_nettype wire

/* dccu_far_model.sv */
`timescale 1ns/100ps
`default_nettype none
module dccu_far_model (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Bench control
    input wire logic run,
    input wire logic load,
    input wire logic [15:0] load_val,
    input wire logic [1:0] pin_lvl,
    // Device side
    input wire logic timer_reset,
    output logic [15:0] shared_timer_count,
    output logic unit1_pin_in,
    output logic unit2_pin_in
);
    // The timer steps on sys_clk alone, so it is always a synchronised counter.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            shared_timer_count <= 16'h0000;
        end else if (load) begin
            shared_timer_count <= load_val;
        end else if (timer_reset) begin
            shared_timer_count <= 16'h0000;
        end else if (run) begin
            shared_timer_count <= shared_timer_count + 16'h0001;
        end
    end
    // Pads are held as inputs by the bench, so no port write can disturb them.
    assign unit1_pin_in = pin_lvl[0];
    assign unit2_pin_in = pin_lvl[1];
endmodule // dccu_far_model
`default_nettype wire

/* tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_top import dccu_pkg::*;;
    logic sys_clk, reset_n, run, load, adc_enabled, timer_reset, adc_start;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd_data;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, wr_resp, rd_resp, pin_lvl;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready;
    logic unit1_pin_in, unit2_pin_in, unit1_pin_out, unit2_pin_out;
    logic [15:0] shared_timer_count, load_val;
    int mismatches, cmp_count, n_rst, n_adc;
    dccu_top u_dccu_top (.*);
    dccu_far_model u_dccu_far_model (.*);
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        if (adc_start) n_adc++;
        if (timer_reset) n_rst++;
    end
    ////////////////////////////////////////////////////////////
    task automatic results();
        if (mismatches == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        int n;
        @(posedge sys_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h000000, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        n = 0;
        do begin
            @(posedge sys_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            n++;
        end while (!s_axi_bvalid && n < 64);
        if (!s_axi_bvalid) begin
            mismatches++;
            results();
        end
        s_axi_bready <= 1'b0;
        wr_resp = s_axi_bresp;
    endtask
    task automatic rd(input logic [7:0] a);
        int n;
        @(posedge sys_clk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        n = 0;
        do begin
            @(posedge sys_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            n++;
        end while (!s_axi_rvalid && n < 64);
        if (!s_axi_rvalid) begin
            mismatches++;
            results();
        end
        s_axi_rready <= 1'b0;
        rd_data = s_axi_rdata;
        rd_resp = s_axi_rresp;
    endtask
    task automatic chk16(input logic [7:0] a, input logic [15:0] exp);
        logic [7:0] lo;
        rd(a);
        lo = rd_data[7:0];
        rd(a + 8'h04);
        chk({16'h0000, rd_data[7:0], lo}, {16'h0000, exp});
    endtask
    task automatic tload(input logic [15:0] v, input logic r);
        @(posedge sys_clk);
        {load, load_val, run} <= {1'b1, v, r};
        @(posedge sys_clk);
        load <= 1'b0;
    endtask
    // Eight cycles cover two sync flops, edge detect, event flop and flag.
    task automatic setpin(input logic l);
        @(posedge sys_clk);
        pin_lvl[0] <= l;
        repeat (8) @(posedge sys_clk);
    endtask
    task automatic pulse();
        setpin(1'b0);
        setpin(1'b1);
    endtask
    // Runs the timer across 0x0010 and parks it at zero, away from any match.
    task automatic sweep();
        tload(16'h000c, 1'b1);
        repeat (8) @(posedge sys_clk);
        tload(16'h0000, 1'b0);
    endtask
    // The pin latch moves on the edge that ends a write, so look half a cycle later.
    task automatic chkpin(input logic exp);
        @(negedge sys_clk);
        chk({31'h0, unit1_pin_out}, {31'h0, exp});
    endtask
    ////////////////////////////////////////////////////////////
    task automatic t_regs();
        rd(OFF_U1_CTRL);
        chk(rd_data, 32'h0);
        chk({30'h0, rd_resp}, {30'h0, RESP_OKAY});
        wr(OFF_U2_CTRL, 8'hff);
        rd(OFF_U2_CTRL);
        chk(rd_data, 32'h3f);
        wr(OFF_U2_CTRL, 8'h00);
        wr(OFF_U2_LOW, 8'ha5);
        wr(OFF_U2_HIGH, 8'h5a);
        chk16(OFF_U2_LOW, 16'h5aa5);
        wr(8'h1c, 8'h01);
        chk({30'h0, wr_resp}, {30'h0, RESP_SLVERR});
        rd(8'h1c);
        chk({30'h0, rd_resp}, {30'h0, RESP_SLVERR});
        chk(rd_data, 32'h0);
    endtask
    task automatic t_cap();
        tload(16'h1234, 1'b0);
        wr(OFF_U1_CTRL, {4'h0, MODE_CAP_RISE});
        wr(OFF_FLAGS, 8'hff);
        setpin(1'b1);
        chk16(OFF_U1_LOW, 16'h1234);
        tload(16'h5678, 1'b0);
        pulse();
        chk16(OFF_U1_LOW, 16'h5678);
        rd(OFF_FLAGS);
        chk(rd_data, 32'h04);
        tload(16'h0abc, 1'b0);
        wr(OFF_U1_CTRL, {4'h0, MODE_CAP_FALL});
        setpin(1'b0);
        tload(16'h0def, 1'b0);
        setpin(1'b1);
        chk16(OFF_U1_LOW, 16'h0abc);
    endtask
    task automatic t_presc();
        wr(OFF_U1_CTRL, 8'h00);
        wr(OFF_U1_CTRL, {4'h0, MODE_CAP_4TH});
        tload(16'h1111, 1'b0);
        repeat (3) pulse();
        chk16(OFF_U1_LOW, 16'h0abc);
        tload(16'h2222, 1'b0);
        pulse();
        chk16(OFF_U1_LOW, 16'h2222);
        // A direct switch keeps the count at four, so the twelfth edge captures.
        wr(OFF_U1_CTRL, {4'h0, MODE_CAP_16TH});
        tload(16'h3333, 1'b0);
        repeat (11) pulse();
        chk16(OFF_U1_LOW, 16'h2222);
        pulse();
        chk16(OFF_U1_LOW, 16'h3333);
    endtask
    task automatic t_cmp();
        wr(OFF_U1_CTRL, 8'h00);
        wr(OFF_U1_LOW, 8'h10);
        wr(OFF_U1_HIGH, 8'h00);
        wr(OFF_U1_CTRL, {4'h0, MODE_SET_HIGH});
        wr(OFF_FLAGS, 8'hff);
        chkpin(1'b0);
        sweep();
        chkpin(1'b1);
        rd(OFF_FLAGS);
        chk(rd_data, 32'h04);
        wr(OFF_U1_CTRL, 8'h00);
        chkpin(1'b0);
        wr(OFF_U1_CTRL, {4'h0, MODE_SET_LOW});
        chkpin(1'b1);
        sweep();
        chkpin(1'b0);
        wr(OFF_U1_CTRL, {4'h0, MODE_TOGGLE});
        sweep();
        chkpin(1'b1);
        wr(OFF_U1_CTRL, {4'h0, MODE_FLAG_ONLY});
        wr(OFF_FLAGS, 8'hff);
        sweep();
        chkpin(1'b1);
        rd(OFF_FLAGS);
        chk(rd_data, 32'h04);
    endtask
    task automatic t_trig();
        wr(OFF_U1_CTRL, 8'h00);
        wr(OFF_U2_LOW, 8'h20);
        wr(OFF_U2_HIGH, 8'h00);
        adc_enabled <= 1'b1;
        wr(OFF_U2_CTRL, {4'h0, MODE_TRIGGER});
        wr(OFF_FLAGS, 8'hff);
        {n_rst, n_adc} = '0;
        tload(16'h001a, 1'b1);
        repeat (16) @(posedge sys_clk);
        tload(16'h0000, 1'b0);
        chk(32'(n_rst), 32'h1);
        chk(32'(n_adc), 32'h1);
        chk({31'h0, unit2_pin_out}, 32'h0);
        rd(OFF_FLAGS);
        chk(rd_data, 32'h01);
        adc_enabled <= 1'b0;
        wr(OFF_U2_CTRL, 8'h00);
        wr(OFF_U1_LOW, 8'h10);
        wr(OFF_U1_CTRL, {4'h0, MODE_TRIGGER});
        {n_rst, n_adc} = '0;
        sweep();
        chk(32'(n_rst), 32'h1);
        chk(32'(n_adc), 32'h0);
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        {reset_n, run, load, load_val, pin_lvl, adc_enabled} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid} = '0;
        {s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'h1;
        {mismatches, cmp_count, n_rst, n_adc} = '0;
        repeat (16) @(posedge sys_clk);
        reset_n <= 1'b1;
        t_regs();
        t_cap();
        t_presc();
        t_cmp();
        t_trig();
        results();
    end
endmodule // tb_top
`default_nettype wire
